/* hdl/dbmt_pkg.sv */
// shared constants, types and decode helpers for the dual byte match timer
package dbmt_pkg;

  // apb geometry
  localparam int          ADDR_W = 20;                // byte address width
  localparam int          DATA_W = 32;                // bus data width

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CONTROL   = 16'hfe18;   // timer_control
  localparam logic [15:0] IDX_PRESCALE  = 16'hfe19;   // prescaler_setup
  localparam logic [15:0] IDX_LOW_CNT   = 16'hfe1a;   // low_count, read only
  localparam logic [15:0] IDX_HIGH_CNT  = 16'hfe1b;   // high_count, read only
  localparam logic [15:0] IDX_LOW_DATA  = 16'hfe1c;   // low_match_data
  localparam logic [15:0] IDX_HIGH_DATA = 16'hfe1d;   // high_match_data
  localparam logic [15:0] IDX_EVENT_CFG = 16'hfe1e;   // event source select

  // timer_control field positions
  localparam int BIT_HIGH_RUN  = 7;
  localparam int BIT_LOW_RUN   = 6;
  localparam int BIT_LENGTH    = 5;
  localparam int BIT_MODE_SEL  = 4;
  localparam int BIT_HIGH_FLAG = 3;
  localparam int BIT_HIGH_IE   = 2;
  localparam int BIT_LOW_FLAG  = 1;
  localparam int BIT_LOW_IE    = 0;

  // prescaler_setup field positions
  localparam int BIT_HIGH_PRE_EN = 7;
  localparam int LSB_HIGH_CODE   = 4;
  localparam int BIT_LOW_PRE_EN  = 3;
  localparam int LSB_LOW_CODE    = 0;

  // reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;

  // slow count clock: one pulse every two cycle clocks
  localparam int          CLK_PERIOD_NS   = 4;
  localparam int          SLOW_PERIOD_NS  = 2 * CLK_PERIOD_NS;
  localparam logic [0:0]  SLOW_DIV_LAST   = 1'((SLOW_PERIOD_NS / CLK_PERIOD_NS) - 1);

  // operating modes
  typedef enum logic [1:0] {MODE_SPLIT, MODE_CASCADE, MODE_FAST} dbmt_mode_t;

  // register selected by an address
  typedef enum logic [2:0] {
    SEL_NONE, SEL_CONTROL, SEL_PRESCALE, SEL_LOW_CNT,
    SEL_HIGH_CNT, SEL_LOW_DATA, SEL_HIGH_DATA, SEL_EVENT_CFG
  } dbmt_sel_t;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction

  // mode from length select and mode select; undefined code runs as split
  function automatic dbmt_mode_t decode_mode(input logic len, input logic sel);
    if (len && sel) decode_mode = MODE_FAST;
    else if (len) decode_mode = MODE_CASCADE;
    else decode_mode = MODE_SPLIT;
  endfunction

endpackage

/* hdl/dbmt_prescaler.sv */
// programmable 8-bit prescaler with a setting held until reload
`timescale 1ns/1ps
module dbmt_prescaler
  import dbmt_pkg::*;
(
  input  wire logic       pclk,      // cycle clock
  input  wire logic       presetn,   // async reset, active low
  input  wire logic       run,       // byte run bit
  input  wire logic       clk_in,    // count clock pulse
  input  wire logic       load,      // take the new setting now
  input  wire logic       set_en,    // written prescale enable
  input  wire logic [2:0] set_code,  // written prescale code
  output logic            tick       // one output pulse per period
);

  // prescaler state
  typedef struct packed {
    logic       en;    // active enable
    logic [2:0] code;  // active code
    logic [7:0] cnt;   // input pulses seen
  } dbmt_pre_t;

  dbmt_pre_t  s_q;
  dbmt_pre_t  s_d;
  logic [8:0] ratio;   // division ratio
  logic [7:0] last;    // count value that ends a period

  // ratio is 1 when disabled, else two to the power code+1
  assign ratio = s_q.en ? (9'h002 << s_q.code) : 9'h001;
  assign last  = 8'(ratio - 9'h001);
  assign tick  = run && clk_in && (s_q.cnt == last);

  // next state
  always_comb begin
    s_d = s_q;
    if (!run) begin
      // stopped: cleared and follows the written setting
      s_d.cnt  = 8'h00;
      s_d.en   = set_en;
      s_d.code = set_code;
    end else begin
      if (clk_in) begin
        s_d.cnt = tick ? 8'h00 : 8'(s_q.cnt + 8'h01);
      end
      if (load) begin
        // new setting only lands with the match buffer reload
        s_d.en   = set_en;
        s_d.code = set_code;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // while running, the active setting only moves at a reload
  a_pre_hold: assert property (@(posedge pclk) disable iff (!presetn) run && !load
                               |=> s_q.en == $past(s_q.en) && s_q.code == $past(s_q.code))
    else $error("prescaler setting changed outside reload");

endmodule

/* hdl/dbmt_byte_counter.sv */
// 8-bit up-counter with a double-buffered match value
`timescale 1ns/1ps
module dbmt_byte_counter
  import dbmt_pkg::*;
(
  input  wire logic       pclk,        // cycle clock
  input  wire logic       presetn,     // async reset, active low
  input  wire logic       run,         // byte run bit
  input  wire logic       step,        // prescaler output pulse
  input  wire logic       free_run,    // wrap through 256, no match clear
  input  wire logic [7:0] match_data,  // software match data
  output logic      [7:0] count,       // counter value
  output logic      [7:0] buffer,      // match buffer
  output logic            match,       // count equals buffer
  output logic            zero_hit     // counter returns to zero
);

  // counter state
  typedef struct packed {
    logic [7:0] cnt;  // count
    logic [7:0] buf_v; // match buffer
  } dbmt_cnt_t;

  dbmt_cnt_t  s_q;
  dbmt_cnt_t  s_d;
  logic [7:0] nxt;   // count after a step

  assign match    = (s_q.cnt == s_q.buf_v);
  assign nxt      = (!free_run && match) ? 8'h00 : 8'(s_q.cnt + 8'h01);
  assign zero_hit = run && step && (nxt == 8'h00);
  assign count    = s_q.cnt;
  assign buffer   = s_q.buf_v;

  // next state
  always_comb begin
    s_d = s_q;
    if (!run) begin
      // stopped: held at zero, buffer tracks the data register
      s_d.cnt   = 8'h00;
      s_d.buf_v = match_data;
    end else begin
      if (step) begin
        s_d.cnt = nxt;
      end
      if (zero_hit) begin
        s_d.buf_v = match_data;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // while running, the match buffer only reloads when the count returns to zero
  a_buf_hold: assert property (@(posedge pclk) disable iff (!presetn) run && !zero_hit
                               |=> buffer == $past(buffer))
    else $error("match buffer changed outside reload");

endmodule

/* hdl/dbmt_top.sv */
// dual byte match timer: apb registers, mode steering and two byte timers
//
// How it works
// - high run off holds counter, buffer follows
// - low run off holds counter, buffer follows
// - length select 0 gives two 8-bit timers
// - length select 1 cascades high after low
// - each byte matches independently in every mode
// - mode from mode select and length select
// - high flag sets when high returns zero
// - low flag sets when low returns zero
// - flags cleared only by software writing zero
// - high enable and flag raise interrupt
// - low enable and flag raise interrupt
// - high prescaler ratio 1 or 2..256
// - low prescaler ratio 1 or 2..256
// - prescaler change lands at buffer reload
// - low counter counts low prescaler pulses
// - high counter counts high prescaler pulses
// - low match compares against low buffer
// - high match compares against high buffer
// - low buffer reloads when low reaches zero
// - high buffer reloads when high reaches zero
// - modes 0, 2, 3 from the two bits
// - low prescaler clock 2 cycles/events, or 1
// - high prescaler clock 2 cycles, low match, rollover
// - low clears on match except mode 3
`timescale 1ns/1ps
module dbmt_top
  import dbmt_pkg::*;
(
  input  wire logic              pclk,         // cycle clock
  input  wire logic              presetn,      // async reset, active low
  input  wire logic              psel,         // apb select
  input  wire logic              penable,      // apb access phase
  input  wire logic              pwrite,       // apb direction
  input  wire logic [ADDR_W-1:0] paddr,        // apb byte address
  input  wire logic [DATA_W-1:0] pwdata,       // apb write data
  output logic      [DATA_W-1:0] prdata,       // apb read data
  output logic                   pready,       // apb ready
  output logic                   pslverr,      // apb error, unmapped address
  input  wire logic              count_event,  // external event pulse
  output logic                   irq,          // shared timer interrupt
  output logic                   low_match,    // low byte match level
  output logic                   high_match    // high byte match level
);

  // state of the block outside the counters and prescalers
  typedef struct packed {
    logic [7:0]        ctrl;       // timer_control
    logic [7:0]        pre;        // prescaler_setup
    logic [7:0]        ldata;      // low_match_data
    logic [7:0]        hdata;      // high_match_data
    logic              evsel;      // low count clock from events
    logic [0:0]        div;        // slow clock divider
    logic [DATA_W-1:0] rdata;      // read data
    logic              ready;      // access phase ready
    logic              err;        // slave error
    logic              irq;        // interrupt request
    logic              lmatch;     // low match level
    logic              hmatch;     // high match level
  } dbmt_state_t;

  dbmt_state_t s_q;
  dbmt_state_t s_d;

  // decoded controls
  logic       high_run;     // high byte running
  logic       low_run;      // low byte running
  dbmt_mode_t mode;         // current mode
  logic       slow_tick;    // one pulse per two cycles
  logic       lo_clk_in;    // low prescaler count clock
  logic       hi_clk_in;    // high prescaler count clock
  logic       lo_tick;      // low prescaler output
  logic       hi_tick;      // high prescaler output
  logic       lo_zero;      // low counter returned to zero
  logic       hi_zero;      // high counter returned to zero
  logic       lo_match_c;   // low match, combinational
  logic       hi_match_c;   // high match, combinational
  logic [7:0] lo_count;     // low counter value
  logic [7:0] hi_count;     // high counter value
  logic [7:0] lo_buffer;    // low match buffer
  logic [7:0] hi_buffer;    // high match buffer

  // bus phases
  logic       setup;        // setup cycle
  logic       access;       // completing access
  logic       wr;           // completing write
  dbmt_sel_t  sel;          // addressed register
  logic       ctrl_wr;      // write to timer_control

  // register selected by an address
  function automatic dbmt_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    if (a == reg_addr(IDX_CONTROL)) reg_sel = SEL_CONTROL;
    else if (a == reg_addr(IDX_PRESCALE)) reg_sel = SEL_PRESCALE;
    else if (a == reg_addr(IDX_LOW_CNT)) reg_sel = SEL_LOW_CNT;
    else if (a == reg_addr(IDX_HIGH_CNT)) reg_sel = SEL_HIGH_CNT;
    else if (a == reg_addr(IDX_LOW_DATA)) reg_sel = SEL_LOW_DATA;
    else if (a == reg_addr(IDX_HIGH_DATA)) reg_sel = SEL_HIGH_DATA;
    else if (a == reg_addr(IDX_EVENT_CFG)) reg_sel = SEL_EVENT_CFG;
    else reg_sel = SEL_NONE;
  endfunction

  // field decode
  assign high_run  = s_q.ctrl[BIT_HIGH_RUN];
  assign low_run   = s_q.ctrl[BIT_LOW_RUN];
  assign mode      = decode_mode(s_q.ctrl[BIT_LENGTH], s_q.ctrl[BIT_MODE_SEL]);
  assign slow_tick = (s_q.div == SLOW_DIV_LAST);

  // low count clock: every cycle in mode 3, else slow clock or events
  assign lo_clk_in = (mode == MODE_FAST) ? 1'b1 : (s_q.evsel ? count_event : slow_tick);

  // high count clock: slow clock when split, low period when cascaded
  assign hi_clk_in = (mode == MODE_SPLIT) ? slow_tick : lo_zero;

  // bus phase decode
  assign setup   = psel && !penable;
  assign access  = psel && penable && s_q.ready;
  assign wr      = access && pwrite;
  assign sel     = reg_sel(paddr);
  assign ctrl_wr = wr && (sel == SEL_CONTROL);

  // low byte prescaler
  dbmt_prescaler u_lo_pre (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (low_run),
    .clk_in   (lo_clk_in),
    .load     (lo_zero),
    .set_en   (s_q.pre[BIT_LOW_PRE_EN]),
    .set_code (s_q.pre[LSB_LOW_CODE +: 3]),
    .tick     (lo_tick)
  );

  // high byte prescaler
  dbmt_prescaler u_hi_pre (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (high_run),
    .clk_in   (hi_clk_in),
    .load     (hi_zero),
    .set_en   (s_q.pre[BIT_HIGH_PRE_EN]),
    .set_code (s_q.pre[LSB_HIGH_CODE +: 3]),
    .tick     (hi_tick)
  );

  // low byte counter, free running only in mode 3
  dbmt_byte_counter u_lo_cnt (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (low_run),
    .step       (lo_tick),
    .free_run   (mode == MODE_FAST),
    .match_data (s_q.ldata),
    .count      (lo_count),
    .buffer     (lo_buffer),
    .match      (lo_match_c),
    .zero_hit   (lo_zero)
  );

  // high byte counter, always cleared on match
  dbmt_byte_counter u_hi_cnt (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (high_run),
    .step       (hi_tick),
    .free_run   (1'b0),
    .match_data (s_q.hdata),
    .count      (hi_count),
    .buffer     (hi_buffer),
    .match      (hi_match_c),
    .zero_hit   (hi_zero)
  );

  // next state: divider, bus slave, flags and outputs
  always_comb begin
    s_d = s_q;
    // slow clock divider
    s_d.div = (s_q.div == SLOW_DIV_LAST) ? 1'b0 : 1'(s_q.div + 1'b1);
    // no wait state: data and ready prepared in the setup cycle
    s_d.ready = setup;
    s_d.err   = setup && (sel == SEL_NONE);
    s_d.rdata = '0;
    if (setup && !pwrite) begin
      case (sel)
        SEL_CONTROL:   s_d.rdata[7:0] = s_q.ctrl;
        SEL_PRESCALE:  s_d.rdata[7:0] = s_q.pre;
        SEL_LOW_CNT:   s_d.rdata[7:0] = lo_count;
        SEL_HIGH_CNT:  s_d.rdata[7:0] = hi_count;
        SEL_LOW_DATA:  s_d.rdata[7:0] = s_q.ldata;
        SEL_HIGH_DATA: s_d.rdata[7:0] = s_q.hdata;
        SEL_EVENT_CFG: s_d.rdata[0]   = s_q.evsel;
        default:       s_d.rdata      = '0;
      endcase
    end
    // register writes; counters are not writable
    if (wr) begin
      case (sel)
        SEL_CONTROL: begin
          s_d.ctrl = pwdata[7:0];
          // flags: zero clears, one keeps the present value
          s_d.ctrl[BIT_HIGH_FLAG] = s_q.ctrl[BIT_HIGH_FLAG] & pwdata[BIT_HIGH_FLAG];
          s_d.ctrl[BIT_LOW_FLAG]  = s_q.ctrl[BIT_LOW_FLAG] & pwdata[BIT_LOW_FLAG];
        end
        SEL_PRESCALE:  s_d.pre   = pwdata[7:0];
        SEL_LOW_DATA:  s_d.ldata = pwdata[7:0];
        SEL_HIGH_DATA: s_d.hdata = pwdata[7:0];
        SEL_EVENT_CFG: s_d.evsel = pwdata[0];
        default:       s_d.evsel = s_q.evsel;
      endcase
    end
    // flag set after the write so that a set wins over a clear
    if (hi_zero) begin
      s_d.ctrl[BIT_HIGH_FLAG] = 1'b1;
    end
    if (lo_zero) begin
      s_d.ctrl[BIT_LOW_FLAG] = 1'b1;
    end
    // shared interrupt from either enabled flag
    s_d.irq = (s_d.ctrl[BIT_HIGH_FLAG] && s_d.ctrl[BIT_HIGH_IE])
           || (s_d.ctrl[BIT_LOW_FLAG] && s_d.ctrl[BIT_LOW_IE]);
    // match levels registered for the pins
    s_d.lmatch = lo_match_c;
    s_d.hmatch = hi_match_c;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q       <= '0;
      s_q.ctrl  <= REG_RESET;
      s_q.pre   <= REG_RESET;
      s_q.ldata <= REG_RESET;
      s_q.hdata <= REG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign prdata     = s_q.rdata;
  assign pready     = s_q.ready;
  assign pslverr    = s_q.err;
  assign irq        = s_q.irq;
  assign low_match  = s_q.lmatch;
  assign high_match = s_q.hmatch;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // setup cycle, then one ready access cycle
  sequence s_ready_once;
    pready ##1 !pready;
  endsequence

  a_apb_ready: assert property (setup |=> s_ready_once)
    else $error("ready not one cycle after setup");
  a_unmapped_err: assert property (setup && sel == SEL_NONE |=> pslverr && pready)
    else $error("unmapped address without error");
  a_read_data: assert property (setup && !pwrite && sel == SEL_LOW_DATA |=> prdata[7:0] == s_q.ldata)
    else $error("low match data read wrong");
  a_stop_low: assert property (!low_run && $past(low_run) == 1'b0 |-> lo_count == 8'h00)
    else $error("stopped low counter not zero");
  a_stop_buf: assert property (!low_run ##1 !low_run |-> lo_buffer == $past(s_q.ldata))
    else $error("stopped low buffer not tracking");
  a_stop_high: assert property (!high_run ##1 !high_run |-> hi_count == 8'h00 && hi_buffer == $past(s_q.hdata))
    else $error("stopped high byte not held");
  a_flag_set: assert property (lo_zero |=> s_q.ctrl[BIT_LOW_FLAG])
    else $error("low flag not set on zero");
  a_flag_hold: assert property (s_q.ctrl[BIT_HIGH_FLAG] && !ctrl_wr |=> s_q.ctrl[BIT_HIGH_FLAG])
    else $error("high flag cleared by hardware");
  a_irq_gate: assert property (irq == ((s_q.ctrl[3] && s_q.ctrl[2]) || (s_q.ctrl[1] && s_q.ctrl[0])))
    else $error("interrupt not flag and enable");
  a_split_clear: assert property (low_run && mode != MODE_FAST && lo_tick && lo_count == lo_buffer
                                  |=> lo_count == 8'h00)
    else $error("low counter not cleared on match");
  a_fast_wrap: assert property (low_run && mode == MODE_FAST && lo_tick && lo_count == 8'hfe
                                ##1 low_run && lo_tick |=> lo_count == 8'h00)
    else $error("low counter did not wrap");

endmodule

/* verif/testbench.sv */
// self-checking testbench for the dual byte match timer
`timescale 1ns/1ps
`define CHK(act, exp) begin n_tests++; if ((act) !== (exp)) begin num_errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end
module testbench;
  import dbmt_pkg::*;
  // register byte addresses, index times four
  localparam logic [ADDR_W-1:0] A_CTL  = {2'b00, IDX_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] A_PRE  = {2'b00, IDX_PRESCALE, 2'b00};
  localparam logic [ADDR_W-1:0] A_LCNT = {2'b00, IDX_LOW_CNT, 2'b00};
  localparam logic [ADDR_W-1:0] A_HCNT = {2'b00, IDX_HIGH_CNT, 2'b00};
  localparam logic [ADDR_W-1:0] A_LDAT = {2'b00, IDX_LOW_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] A_HDAT = {2'b00, IDX_HIGH_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] A_EVT  = {2'b00, IDX_EVENT_CFG, 2'b00};
  localparam logic [ADDR_W-1:0] A_BAD  = 20'h00004;  // unmapped word
  logic              pclk;         // cycle clock
  logic              presetn;      // reset, active low
  logic              psel;         // apb select
  logic              penable;      // apb access phase
  logic              pwrite;       // apb direction
  logic [ADDR_W-1:0] paddr;        // apb address
  logic [DATA_W-1:0] pwdata;       // apb write data
  logic [DATA_W-1:0] prdata;       // apb read data
  logic              pready;       // apb ready
  logic              pslverr;      // apb error
  logic              count_event;  // external event pulse
  logic              irq;          // shared interrupt
  logic              low_match;    // low byte match level
  logic              high_match;   // high byte match level
  int                num_errors;   // mismatches seen
  int                n_tests;      // comparisons made
  logic [DATA_W:0]   notes[$];     // expected {pslverr, prdata} per transfer
  logic [DATA_W:0]   oldest;       // note taken off the queue
  logic              ev_on;        // events drive the low prescaler
  int                ev_cnt;       // spacing of event pulses
  logic [7:0]        rnd;          // random register value
  int                nl;           // random low match data
  int                mh;           // random high match data

  dbmt_top dbmt_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_event(count_event), .irq(irq), .low_match(low_match), .high_match(high_match)
  );

  // free-running cycle clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // events every fifth cycle when selected, random noise otherwise
  always @(posedge pclk) begin
    ev_cnt <= (ev_cnt == 4) ? 0 : ev_cnt + 1;
    count_event <= ev_on ? (ev_cnt == 4) : 1'($urandom);
  end

  // bus monitor: each completed transfer is compared with the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      oldest = (notes.size() > 0) ? notes.pop_front() : {1'b1, {DATA_W{1'b1}}};
      `CHK({pslverr, prdata}, oldest)
    end
  end

  // verdict and end of run
  task automatic test_done;
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one apb transfer; every transfer notes its expected answer first
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [DATA_W:0] ex);
    int k;
    notes.push_back(ex);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (k == 100) `CHK(pready, 1'b1)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, '0);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic err);
    xfer(1'b0, a, 8'h00, {err, 24'h0, d});
  endtask

  // cycles between the second and third rising edge of a match output
  task automatic measure(input logic hi, input int exp);
    int   t;
    int   t2;
    int   rises;
    logic prev;
    logic cur;
    t = 0;
    t2 = 0;
    rises = 0;
    prev = 1'b1;
    while (rises < 3 && t < 20000) begin
      @(posedge pclk);
      t++;
      cur = hi ? high_match : low_match;
      if (cur === 1'b1 && prev !== 1'b1) begin
        rises++;
        if (rises == 2) t2 = t;
      end
      prev = cur;
    end
    `CHK(32'(t - t2), 32'(exp))
  endtask

  // configure while stopped, run, measure a period, then flags, irq and stop
  task automatic run_case(input logic [7:0] ctrl, input logic [7:0] pre, input logic [7:0] ld,
                          input logic [7:0] hd, input logic hi, input int exp, input logic evt);
    logic [7:0] flg;
    flg = (ctrl[7] ? 8'h08 : 8'h00) | (ctrl[6] ? 8'h02 : 8'h00);
    wr(A_CTL, 8'h00);
    wr(A_EVT, {7'h0, evt});
    ev_on <= evt;
    wr(A_PRE, pre);
    wr(A_LDAT, ld);
    wr(A_HDAT, hd);
    wr(A_CTL, ctrl);
    measure(hi, exp);
    rd(A_CTL, ctrl | flg, 1'b0);
    wr(A_CTL, ctrl | 8'h0a);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    wr(A_CTL, ctrl | 8'h0f);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(A_CTL, 8'h00);
    wr(A_CTL, 8'h00);
    rd(A_CTL, 8'h00, 1'b0);
    rd(A_LCNT, 8'h00, 1'b0);
    rd(A_HCNT, 8'h00, 1'b0);
    ev_on <= 1'b0;
  endtask

  // watchdog against a hung handshake or a dead timer
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    test_done();
  end

  // main sequence
  initial begin
    void'($urandom(32'h3403));
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    count_event = 1'b0;
    ev_on = 1'b0;
    ev_cnt = 0;
    num_errors = 0;
    n_tests = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and the unmapped word
    rd(A_CTL, 8'h00, 1'b0);
    rd(A_PRE, 8'h00, 1'b0);
    rd(A_LCNT, 8'h00, 1'b0);
    rd(A_HCNT, 8'h00, 1'b0);
    rd(A_LDAT, 8'h00, 1'b0);
    rd(A_HDAT, 8'h00, 1'b0);
    xfer(1'b1, A_BAD, 8'hff, {1'b1, 32'h0});
    rd(A_BAD, 8'h00, 1'b1);
    // random readback, counter writes ignored
    rnd = 8'($urandom);
    wr(A_PRE, rnd);
    rd(A_PRE, rnd, 1'b0);
    rnd = 8'($urandom);
    wr(A_LDAT, rnd);
    rd(A_LDAT, rnd, 1'b0);
    rnd = 8'($urandom);
    wr(A_HDAT, rnd);
    rd(A_HDAT, rnd, 1'b0);
    wr(A_LCNT, 8'hff);
    wr(A_HCNT, 8'hff);
    rd(A_LCNT, 8'h00, 1'b0);
    rd(A_HCNT, 8'h00, 1'b0);
    // writing ones to the flags never sets them
    wr(A_CTL, 8'h3f);
    rd(A_CTL, 8'h35, 1'b0);
    `CHK(irq, 1'b0)
    // every low and high prescaler code, mode 0
    for (int n = 0; n < 8; n++) begin
      run_case(8'h40, 8'(8'h08 | n), 8'h01, 8'h00, 1'b0, 2 * (2 << n) * 2, 1'b0);
      run_case(8'h80, 8'(8'h80 | (n << 4)), 8'h00, 8'h01, 1'b1, 2 * (2 << n) * 2, 1'b0);
    end
    nl = 1 + int'($urandom % 7);
    mh = 1 + int'($urandom % 3);
    // prescaler off, then external events, then cascaded and fast modes
    run_case(8'h40, 8'h00, 8'(nl), 8'h00, 1'b0, (nl + 1) * 2, 1'b0);
    run_case(8'h40, 8'h00, 8'(nl), 8'h00, 1'b0, (nl + 1) * 5, 1'b1);
    run_case(8'he0, 8'h00, 8'(nl), 8'(mh), 1'b1, (mh + 1) * (nl + 1) * 2, 1'b0);
    run_case(8'hf0, 8'h00, 8'(nl), 8'h00, 1'b0, 256, 1'b0);
    run_case(8'hf0, 8'h00, 8'(nl), 8'(mh), 1'b1, (mh + 1) * 256, 1'b0);
    test_done();
  end
endmodule
